/* File: hw/hpp_pkg.sv */
// Package holding the constants shared by both ends of the host parallel port.
package hpp_pkg;

  // Status byte field positions.
  localparam int STS_TX_EMPTY_BIT = 7;
  localparam int STS_RX_FULL_BIT  = 6;
  localparam int STS_TAG_MSB      = 3;
  localparam int STS_TAG_LSB      = 0;

  // Address line values.
  localparam logic MODE_MSG  = 1'b0;
  localparam logic MODE_FAST = 1'b1;
  localparam logic PATH_DATA = 1'b0;
  localparam logic PATH_CTRL = 1'b1;

  // Reset values.
  localparam logic [7:0] STATUS_RST   = 8'h80;
  localparam logic [3:0] FLOW_TAG_RST = 4'h0;

  // Strobe timing, in ns, and derived clock counts at 100 MHz.
  localparam int CLK_PERIOD_NS    = 10;
  localparam int STROBE_LOW_NS    = 10;
  localparam int STROBE_GAP_NS    = 5;
  localparam int READY_LOW_MIN_NS = 15;
  // Two sync flops and the read data register sit between the strobe's
  // fall and valid data, so the host samples one edge after that.
  localparam int STROBE_LOW_CYC   =
    (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 3;
  localparam int STROBE_GAP_CYC   =
    (STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int READY_LOW_CYC    =
    (READY_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host register port offsets.
  localparam logic [3:0] HREG_CMD    = 4'h0;
  localparam logic [3:0] HREG_WDATA  = 4'h1;
  localparam logic [3:0] HREG_RDATA  = 4'h2;
  localparam logic [3:0] HREG_STATUS = 4'h3;
  localparam logic [3:0] HREG_ADDR   = 4'h4;

  // Host command codes written to the command register.
  localparam logic [2:0] CMD_MSG_WR_DATA = 3'h0;
  localparam logic [2:0] CMD_MSG_WR_CTRL = 3'h1;
  localparam logic [2:0] CMD_MSG_RD_DATA = 3'h2;
  localparam logic [2:0] CMD_MSG_RD_STS  = 3'h3;
  localparam logic [2:0] CMD_FAST_WR     = 3'h4;
  localparam logic [2:0] CMD_FAST_RD     = 3'h5;

endpackage

/* File: hw/hpp_if.sv */
// Interface carrying the host parallel port pins between the two ends.
`timescale 1ns/100ps
interface hpp_if;
  logic        cs_n;
  logic        rd_n;
  logic        wr_n;
  logic [1:0]  addr;
  logic [15:0] host_d;
  logic        host_d_oe;
  logic [15:0] dev_d;
  logic        dev_d_oe;
  logic        irq;
  logic        transfer_ready_out;

  modport device (
    input  cs_n, rd_n, wr_n, addr, host_d,
    output dev_d, dev_d_oe, irq, transfer_ready_out
  );
  modport host (
    input  dev_d, irq, transfer_ready_out,
    output cs_n, rd_n, wr_n, addr, host_d, host_d_oe
  );
endinterface

/* File: hw/hpp_device.sv */
// Device end of the host parallel port: message channel and fast path.
//
// Contract
// - Upper address low selects byte message mode
// - Upper address high: fast mode, lower ignored
// - Message read with lower address high returns status
// - Status: tx empty, rx full, two zeros, tag
// - Tx empty low while byte pending, irq high
// - Tx empty always inverse of irq
// - Message data read consumes byte, clears irq
// - Irq falls on read strobe rising edge
// - Rx full blocks host writes; the device still latches a write while only the cpu fifo full bit sets rx full
// - Host waits irq, reads tag, reads data
// - Host may poll tx empty instead of irq
// - Host polls rx full then writes
// - Rx full holds while cpu fifo full
// - Rx full holds while write not transferred
// - Fast mode bus is 8 or 16 bits
// - Fast mode reaches internal bus, firmware config
// - Ready low after strobe rise until done
// - Firmware image loadable from host at power-up
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
module hpp_device
  import hpp_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int ADDR_W = 24
)(
  // Clock and reset.
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  // Host pins.
  hpp_if.device                  pins,
  // Control cpu message side.
  input  wire logic              cpu_tx_valid_i,
  input  wire logic [7:0]        cpu_tx_byte_i,
  input  wire logic [3:0]        cpu_flow_tag_i,
  output logic                   cpu_tx_busy_o,
  output logic                   cpu_rx_valid_o,
  output logic [7:0]             cpu_rx_byte_o,
  output logic                   cpu_rx_is_ctrl_o,
  input  wire logic              cpu_rx_taken_i,
  input  wire logic              cpu_fifo_full_bit_i,
  // Firmware configuration of the fast path.
  input  wire logic              cfg_wide_i,
  input  wire logic              cfg_burst_i,
  input  wire logic              cfg_write_dir_i,
  input  wire logic [ADDR_W-1:0] cfg_base_addr_i,
  input  wire logic              boot_load_i,
  // Internal asynchronous bus master.
  output logic                   ibus_req_o,
  output logic                   ibus_we_o,
  output logic [ADDR_W-1:0]      ibus_addr_o,
  output logic [DATA_W-1:0]      ibus_wdata_o,
  input  wire logic              ibus_ack_i,
  input  wire logic [DATA_W-1:0] ibus_rdata_i
);

  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_HOLD} hpp_fast_t;

  logic [2:0]        cs_sync_ff, rd_sync_ff, wr_sync_ff;
  logic [1:0]        addr_sync_ff [2];
  logic [15:0]       d_sync_ff [2];
  logic              rd_rise, wr_rise, rd_fall, sel_mode, sel_path;
  logic              tx_pend_ff;
  logic [7:0]        tx_byte_ff;
  logic [3:0]        flow_tag_ff;
  logic              rx_held_ff, rx_ctrl_ff;
  logic [7:0]        rx_byte_ff;
  logic              rx_full_flag;
  logic [7:0]        status;
  logic [DATA_W-1:0] dout_ff;
  logic              dout_oe_ff;
  logic [ADDR_W-1:0] addr_cnt_ff;
  logic              ready_ff;
  logic [1:0]        rlow_ff;
  hpp_fast_t         fast_st_ff;
  logic              req_ff, we_ff;
  logic [DATA_W-1:0] wdata_ff;

  // Strobes pass two flops; edges compare stages two and three only.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      cs_sync_ff <= 3'h7;
      rd_sync_ff <= 3'h7;
      wr_sync_ff <= 3'h7;
    end
    else
    begin
      cs_sync_ff <= {cs_sync_ff[1:0], pins.cs_n};
      rd_sync_ff <= {rd_sync_ff[1:0], pins.rd_n};
      wr_sync_ff <= {wr_sync_ff[1:0], pins.wr_n};
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    addr_sync_ff[0] <= pins.addr;
    addr_sync_ff[1] <= addr_sync_ff[0];
    d_sync_ff[0]    <= pins.host_d;
    d_sync_ff[1]    <= d_sync_ff[0];
  end

  // Chip select is taken from the stage where the strobe is low: stage three for rises, stage two for falls.
  assign rd_rise  = rd_sync_ff[1] & ~rd_sync_ff[2] & ~cs_sync_ff[2];
  assign wr_rise  = wr_sync_ff[1] & ~wr_sync_ff[2] & ~cs_sync_ff[2];
  assign rd_fall  = ~rd_sync_ff[1] & rd_sync_ff[2] & ~cs_sync_ff[1];
  assign sel_mode = addr_sync_ff[1][1];
  assign sel_path = addr_sync_ff[1][0];

  // Outbound message byte; consumed only at the read strobe's rise.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      tx_pend_ff  <= 1'b0;
      tx_byte_ff  <= 8'h00;
      flow_tag_ff <= FLOW_TAG_RST;
    end
    else if (rd_rise && sel_mode == MODE_MSG && sel_path == PATH_DATA)
      tx_pend_ff <= 1'b0;
    else if (cpu_tx_valid_i && !tx_pend_ff)
    begin
      tx_pend_ff  <= 1'b1;
      tx_byte_ff  <= cpu_tx_byte_i;
      flow_tag_ff <= cpu_flow_tag_i;
    end
  end

  assign cpu_tx_busy_o = tx_pend_ff;
  assign pins.irq      = tx_pend_ff;

  // Inbound byte held until the cpu takes it; offered to the cpu only while its fifo has room.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      rx_held_ff <= 1'b0;
      rx_ctrl_ff <= 1'b0;
      rx_byte_ff <= 8'h00;
    end
    else if (wr_rise && sel_mode == MODE_MSG && !rx_held_ff)
    begin
      rx_held_ff <= 1'b1;
      rx_ctrl_ff <= (sel_path == PATH_CTRL);
      rx_byte_ff <= d_sync_ff[1][7:0];
    end
    else if (cpu_rx_taken_i)
      rx_held_ff <= 1'b0;
  end

  assign cpu_rx_valid_o   = rx_held_ff & ~cpu_fifo_full_bit_i;
  assign cpu_rx_byte_o    = rx_byte_ff;
  assign cpu_rx_is_ctrl_o = rx_ctrl_ff;
  assign rx_full_flag     = rx_held_ff | cpu_fifo_full_bit_i;

  assign status = {~tx_pend_ff, rx_full_flag, 2'b00, flow_tag_ff};

  // Read data launched at the strobe's fall, held until it rises.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      dout_ff    <= '0;
      dout_oe_ff <= 1'b0;
    end
    else if (rd_fall)
    begin
      dout_oe_ff <= 1'b1;
      if (sel_mode == MODE_FAST)
        dout_ff <= ibus_rdata_i;
      else if (sel_path == PATH_CTRL)
        dout_ff <= DATA_W'(status);
      else
        dout_ff <= DATA_W'(tx_byte_ff);
    end
    else if (rd_sync_ff[1] || cs_sync_ff[1])
      dout_oe_ff <= 1'b0;
  end

  assign pins.dev_d    = dout_ff;
  assign pins.dev_d_oe = dout_oe_ff;

  // Fast path: each strobe rise seen in ST_IDLE starts one internal bus access.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      fast_st_ff  <= ST_IDLE;
      ready_ff    <= 1'b1;
      rlow_ff     <= 2'd0;
      req_ff      <= 1'b0;
      we_ff       <= 1'b0;
      wdata_ff    <= '0;
      addr_cnt_ff <= '0;
    end
    else
    begin
      unique case (fast_st_ff)
        ST_IDLE:
          if ((rd_rise || wr_rise) && sel_mode == MODE_FAST)
          begin
            fast_st_ff <= ST_BUSY;
            ready_ff   <= 1'b0;
            rlow_ff    <= 2'd0;
            req_ff     <= 1'b1;
            we_ff      <= wr_rise & (cfg_write_dir_i | boot_load_i);
            wdata_ff   <= cfg_wide_i ? d_sync_ff[1][DATA_W-1:0]
                                     : DATA_W'(d_sync_ff[1][7:0]);
          end
        ST_BUSY:
        begin
          if (rlow_ff != 2'(READY_LOW_CYC))
            rlow_ff <= rlow_ff + 2'd1;
          if (ibus_ack_i)
          begin
            req_ff      <= 1'b0;
            fast_st_ff  <= ST_HOLD;
            addr_cnt_ff <= cfg_burst_i ? addr_cnt_ff + ADDR_W'(1)
                                       : cfg_base_addr_i;
          end
        end
        ST_HOLD:
          if (rlow_ff >= 2'(READY_LOW_CYC - 1))
          begin
            ready_ff   <= 1'b1;
            fast_st_ff <= ST_IDLE;
          end
          else
            rlow_ff <= rlow_ff + 2'd1;
      endcase
      if (!cfg_burst_i && fast_st_ff == ST_IDLE)
        addr_cnt_ff <= cfg_base_addr_i;
    end
  end

  assign pins.transfer_ready_out = ready_ff;
  assign ibus_req_o   = req_ff;
  assign ibus_we_o    = we_ff;
  assign ibus_addr_o  = addr_cnt_ff;
  assign ibus_wdata_o = wdata_ff;

endmodule

/* File: hw/hpp_host.sv */
// Host end of the host parallel port, driven from a small register port.
`timescale 1ns/100ps
module hpp_host
  import hpp_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // Register port.
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [15:0]      reg_rdata_o,
  // Device pins.
  hpp_if.host              pins
);

  typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_GAP, HS_WAIT} hpp_hst_t;

  hpp_hst_t    st_ff;
  logic [2:0]  cmd_ff;
  logic [15:0] wdata_ff, rdata_ff, rd_out_ff;
  logic [3:0]  cnt_ff;
  logic [1:0]  irq_sync_ff, rdy_sync_ff;
  logic        is_rd, is_fast;
  logic        done_ff;
  logic        poll_ff;
  logic        full_seen_ff;

  always_ff @(posedge core_clk_i)
  begin
    irq_sync_ff <= {irq_sync_ff[0], pins.irq};
    rdy_sync_ff <= {rdy_sync_ff[0], pins.transfer_ready_out};
  end

  assign is_rd   = cmd_ff == CMD_MSG_RD_DATA || cmd_ff == CMD_MSG_RD_STS
                || cmd_ff == CMD_FAST_RD;
  assign is_fast = cmd_ff == CMD_FAST_WR || cmd_ff == CMD_FAST_RD;

  // Message writes first poll status until rx full reads clear.
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_ff    <= HS_IDLE;
      cmd_ff   <= CMD_MSG_RD_STS;
      wdata_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      cnt_ff   <= 4'h0;
      done_ff  <= 1'b0;
      poll_ff  <= 1'b0;
      full_seen_ff <= 1'b0;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == HREG_WDATA)
        wdata_ff <= reg_wdata_i;
      unique case (st_ff)
        HS_IDLE:
          if (reg_wr_i && reg_addr_i == HREG_CMD)
          begin
            cmd_ff  <= reg_wdata_i[2:0];
            cnt_ff  <= 4'h0;
            done_ff <= 1'b0;
            poll_ff <= reg_wdata_i[2:0] == CMD_MSG_WR_DATA
                    || reg_wdata_i[2:0] == CMD_MSG_WR_CTRL;
            st_ff   <= HS_WAIT;
          end
        HS_WAIT:
          if (!is_fast || rdy_sync_ff[1])
            st_ff <= HS_LOW;
        HS_LOW:
          if (cnt_ff == 4'(STROBE_LOW_CYC - 1))
          begin
            if (is_rd)
              rdata_ff <= pins.dev_d;
            if (poll_ff)
              full_seen_ff <= pins.dev_d[STS_RX_FULL_BIT];
            cnt_ff <= 4'h0;
            st_ff  <= HS_GAP;
          end
          else
            cnt_ff <= cnt_ff + 4'h1;
        HS_GAP:
          if (cnt_ff == 4'(STROBE_GAP_CYC - 1))
          begin
            cnt_ff <= 4'h0;
            // The path bit moves only once chip select is high again, so a
            // poll can never be taken for a data read that consumes a byte.
            if (poll_ff)
            begin
              poll_ff <= full_seen_ff;
              st_ff   <= HS_WAIT;
            end
            else
            begin
              done_ff <= 1'b1;
              st_ff   <= HS_IDLE;
            end
          end
          else
            cnt_ff <= cnt_ff + 4'h1;
      endcase
    end
  end

  assign pins.cs_n      = ~(st_ff == HS_LOW || st_ff == HS_GAP);
  assign pins.rd_n      = ~(st_ff == HS_LOW && (is_rd || poll_ff));
  assign pins.wr_n      = ~(st_ff == HS_LOW && !is_rd && !poll_ff);
  assign pins.addr      = {is_fast ? MODE_FAST : MODE_MSG,
                           (cmd_ff == CMD_MSG_WR_CTRL
                            || cmd_ff == CMD_MSG_RD_STS
                            || poll_ff)};
  assign pins.host_d    = wdata_ff;
  assign pins.host_d_oe = st_ff != HS_IDLE && !is_rd && !poll_ff;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      rd_out_ff <= 16'h0000;
    else if (reg_rd_i)
      unique case (reg_addr_i)
        HREG_RDATA:  rd_out_ff <= rdata_ff;
        HREG_STATUS: rd_out_ff <= {13'h0000, done_ff, irq_sync_ff[1],
                                   rdy_sync_ff[1]};
        HREG_CMD:    rd_out_ff <= {13'h0000, cmd_ff};
        default:     rd_out_ff <= 16'h0000;
      endcase
  end

  assign reg_rdata_o = rd_out_ff;

endmodule

/* File: tb/hpp_checker.sv */
// Checker watching the host parallel port pins between both ends.
`timescale 1ns/100ps
module hpp_checker (
  // Clock and reset.
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  // Port pins.
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic [1:0]  addr,
  input wire logic [15:0] dev_d,
  input wire logic        dev_d_oe,
  input wire logic        irq,
  input wire logic        transfer_ready_out
);
  // Ages saturate so a long idle spell never wraps into a false cause.
  logic [3:0] fast_age_ff;
  logic [3:0] rd_age_ff;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      fast_age_ff <= 4'hF;
    else if (!cs_n && addr[1] && !(rd_n && wr_n))
      fast_age_ff <= 4'h0;
    else if (fast_age_ff != 4'hF)
      fast_age_ff <= fast_age_ff + 4'h1;
  end
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      rd_age_ff <= 4'hF;
    else if (!cs_n && !rd_n)
      rd_age_ff <= 4'h0;
    else if (rd_age_ff != 4'hF)
      rd_age_ff <= rd_age_ff + 4'h1;
  end
  sequence s_sts_end;
    (!cs_n && !rd_n && addr == 2'b01)[*3] ##1 (rd_n && !cs_n);
  endsequence
  sequence s_data_end;
    (!cs_n && !rd_n && addr == 2'b00)[*3] ##1 (rd_n && !cs_n);
  endsequence
  property p_irq_hold;
    (!cs_n && !rd_n && irq) |=> irq;
  endproperty
  property p_irq_drop;
    (s_data_end ##0 irq) |-> ##[1:8] !irq;
  endproperty
  property p_sts_keep;
    (s_sts_end ##0 irq) |=> irq[*6];
  endproperty
  property p_sts_byte;
    s_sts_end |-> dev_d_oe && (dev_d[7] == !irq) && (dev_d[5:4] == 2'b00);
  endproperty
  property p_rdy_drop;
    ((!cs_n && addr[1] && !(rd_n && wr_n)) ##1 (rd_n && wr_n))
      |-> ##[1:7] !transfer_ready_out;
  endproperty
  property p_rdy_width;
    $fell(transfer_ready_out) |=> !transfer_ready_out;
  endproperty
  property p_rdy_cause;
    $fell(transfer_ready_out) |-> fast_age_ff <= 4'h7;
  endproperty
  property p_oe_cause;
    dev_d_oe |-> rd_age_ff <= 4'h6;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq hold");
  a_irq_drop: assert property (p_irq_drop) else $error("irq drop");
  a_sts_keep: assert property (p_sts_keep) else $error("sts keep");
  a_sts_byte: assert property (p_sts_byte) else $error("sts byte");
  a_rdy_drop: assert property (p_rdy_drop) else $error("rdy drop");
  a_rdy_width: assert property (p_rdy_width) else $error("rdy wid");
  a_rdy_cause: assert property (p_rdy_cause) else $error("rdy why");
  a_oe_cause: assert property (p_oe_cause) else $error("oe why");
endmodule

/* File: tb/tb_host_parallel_port.sv */
// Testbench joining both ends of the host parallel port.
`timescale 1ns/100ps
module tb_host_parallel_port;
  import hpp_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  ra = 4'h0;
  logic [15:0] wd = 16'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        tv = 1'b0;
  logic [7:0]  tb_b = 8'h0;
  logic [3:0]  tg = 4'h0;
  logic        take = 1'b0;
  logic        ffull = 1'b0;
  logic        wide = 1'b1;
  logic        burst = 1'b0;
  logic        dir = 1'b1;
  logic [23:0] base = 24'h0;
  logic        ack = 1'b0;
  logic [15:0] ird = 16'h0;
  logic [15:0] rdat, iwd, rv, w, e, m, srd;
  logic        busy, rxv, rxc, req, we;
  logic [7:0]  rxb;
  logic [23:0] iadr, prv;
  logic [56:0] tr;
  logic [56:0] q[$];
  int          n_errors = 0;
  int          check_count = 0;
  int          seed = 79;
  int          cyc = 0;
  int          dly = 0;
  int          j, k;
  hpp_if hpp_bus ();
  hpp_host hpp_host_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .pins(hpp_bus));
  hpp_device hpp_device_inst (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .pins(hpp_bus), .cpu_tx_valid_i(tv),
    .cpu_tx_byte_i(tb_b), .cpu_flow_tag_i(tg), .cpu_tx_busy_o(busy),
    .cpu_rx_valid_o(rxv), .cpu_rx_byte_o(rxb), .cpu_rx_is_ctrl_o(rxc),
    .cpu_rx_taken_i(take), .cpu_fifo_full_bit_i(ffull),
    .cfg_wide_i(wide), .cfg_burst_i(burst), .cfg_write_dir_i(dir),
    .cfg_base_addr_i(base), .boot_load_i(1'b0), .ibus_req_o(req),
    .ibus_we_o(we), .ibus_addr_o(iadr), .ibus_wdata_o(iwd),
    .ibus_ack_i(ack), .ibus_rdata_i(ird));
  hpp_checker hpp_checker_inst (.core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i), .cs_n(hpp_bus.cs_n), .rd_n(hpp_bus.rd_n),
    .wr_n(hpp_bus.wr_n), .addr(hpp_bus.addr), .dev_d(hpp_bus.dev_d),
    .dev_d_oe(hpp_bus.dev_d_oe), .irq(hpp_bus.irq),
    .transfer_ready_out(hpp_bus.transfer_ready_out));
  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rw(input logic [3:0] a, input logic [15:0] d, input logic wn);
    @(posedge core_clk_i);
    ra <= a;
    wd <= d;
    wr <= wn;
    rd <= !wn;
    @(posedge core_clk_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 rv = rdat;
  endtask
  task automatic poll();
    for (int i = 0; i < 300; i++)
    begin
      rw(HREG_STATUS, 16'h0, 1'b0);
      if (rv[2] === 1'b1)
        break;
    end
    chk(24'(rv[2]), 24'h1);
  endtask
  task automatic run(input logic [2:0] c);
    rw(HREG_CMD, {13'h0, c}, 1'b1);
    poll();
  endtask
  task automatic sts();
    run(CMD_MSG_RD_STS);
    rw(HREG_RDATA, 16'h0, 1'b0);
  endtask
  task automatic wait_rx();
    for (j = 0; j < 40 && rxv !== 1'b1; j++)
      @(posedge core_clk_i);
  endtask
  task automatic give();
    @(posedge core_clk_i);
    take <= 1'b1;
    @(posedge core_clk_i);
    take <= 1'b0;
  endtask
  // Each internal access is recorded as {we, addr, wdata, rdata}.
  task automatic fchk(input logic w_e, input logic [15:0] mk, input int n);
    for (int i = 0; i < 60 && q.size() == 0; i++)
      @(posedge core_clk_i);
    if (q.size() == 0)
      chk(24'h1, 24'h0);
    else
    begin
      tr = q.pop_front();
      chk(24'(tr[56]), 24'(w_e));
      chk(24'(tr[31:16] & mk), 24'(w & mk));
      if (!burst)
        chk(tr[55:32], base);
      else if (n > 0)
        chk(tr[55:32], prv + 24'h1);
      prv = tr[55:32];
    end
  endtask
  // Internal bus slave with a random wait before each acknowledge after the first.
  always @(posedge core_clk_i)
  begin
    ack <= 1'b0;
    if (req && !ack)
    begin
      if (dly > 0)
        dly--;
      else
      begin
        srd = $random(seed);
        ack <= 1'b1;
        ird <= srd;
        q.push_back({we, iadr, iwd, srd});
        dly = $unsigned($random(seed)) % 5;
      end
    end
  end
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (5) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    for (k = 0; k < 3; k++)
    begin
      @(posedge core_clk_i);
      tv <= 1'b1;
      tb_b <= $random(seed);
      tg <= $random(seed);
      @(posedge core_clk_i);
      tv <= 1'b0;
      for (j = 0; j < 40 && hpp_bus.irq !== 1'b1; j++)
        @(posedge core_clk_i);
      chk(24'(busy), 24'h1);
      sts();
      chk(24'({rv[7], rv[5:0]}), 24'({3'b000, tg}));
      run(CMD_MSG_RD_DATA);
      rw(HREG_RDATA, 16'h0, 1'b0);
      chk(24'(rv[7:0]), 24'(tb_b));
      sts();
      chk(24'({rv[7], hpp_bus.irq, busy}), 24'h4);
    end
    w = $random(seed);
    rw(HREG_WDATA, w, 1'b1);
    run(CMD_MSG_WR_DATA);
    @(posedge core_clk_i);
    ffull <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    chk(24'(rxv), 24'h0);
    sts();
    chk(24'(rv[STS_RX_FULL_BIT]), 24'h1);
    rw(HREG_WDATA, ~w, 1'b1);
    rw(HREG_CMD, {13'h0, CMD_MSG_WR_CTRL}, 1'b1);
    repeat (20) @(posedge core_clk_i);
    rw(HREG_STATUS, 16'h0, 1'b0);
    chk(24'(rv[2]), 24'h0);
    ffull <= 1'b0;
    wait_rx();
    chk(24'({rxc, rxb}), 24'({1'b0, w[7:0]}));
    give();
    poll();
    wait_rx();
    chk(24'({rxc, rxb}), 24'({1'b1, ~w[7:0]}));
    give();
    sts();
    chk(24'(rv[STS_RX_FULL_BIT]), 24'h0);
    for (k = 0; k < 4; k++)
    begin
      @(posedge core_clk_i);
      wide <= k[0];
      burst <= k[1];
      dir <= (k != 3);
      base <= $random(seed);
      m = k[0] ? 16'hFFFF : 16'h00FF;
      for (int n = 0; n < 2; n++)
      begin
        w = $random(seed);
        rw(HREG_WDATA, w, 1'b1);
        run(CMD_FAST_WR);
        fchk(dir, dir ? m : 16'h0, n);
      end
      e = ird;
      run(CMD_FAST_RD);
      rw(HREG_RDATA, 16'h0, 1'b0);
      chk(24'(rv & m), 24'(e & m));
      fchk(1'b0, 16'h0, 2);
    end
    report_and_stop();
  end
endmodule
